// [design/smsp_pkg.sv]
/*
  Constants shared by the switch monitor serial port: frame length, response layout,
  command codes, reset values and the bit positions of the synchronised input bundle.
  Assumes a single 40 MHz system clock domain; every pin is asynchronous to it.
*/
package smsp_pkg;

  // ************************************************************
  // Frame and response layout.
  // ************************************************************
  localparam int unsigned   FRAME_BITS  = 24;
  localparam int unsigned   NUM_PROG    = 8;
  localparam int unsigned   NUM_GND     = 14;
  localparam int unsigned   NUM_SW      = NUM_PROG + NUM_GND;
  localparam int unsigned   CNT_W       = 6;
  localparam logic [5:0]    CNT_MAX     = 6'h3f;
  localparam logic [5:0]    CNT_FRAME   = 6'h18;
  localparam int unsigned   POS_THERMAL = 23;
  localparam int unsigned   POS_RESET   = 22;
  localparam int unsigned   POS_GND_LO  = 8;
  localparam int unsigned   POS_PROG_LO = 0;

  // ************************************************************
  // Command codes, carried in the top byte of the command word.
  // ************************************************************
  localparam logic [7:0]    CMD_SETTINGS = 8'h01;
  localparam logic [7:0]    CMD_WAKE_SP  = 8'h02;
  localparam logic [7:0]    CMD_WAKE_SG  = 8'h03;
  localparam logic [7:0]    CMD_SLEEP    = 8'h0c;

  // ************************************************************
  // Reset values of the programmed settings.
  // ************************************************************
  localparam logic [7:0]    RST_PROG_BAT = 8'hff;
  localparam logic [7:0]    RST_EN_SP    = 8'hff;
  localparam logic [13:0]   RST_EN_SG    = 14'h3fff;

  // ************************************************************
  // Synchroniser bundle: positions and idle values.
  // ************************************************************
  localparam int unsigned   SYNC_W      = 30;
  localparam int unsigned   SY_PROG_LO  = 0;
  localparam int unsigned   SY_GND_LO   = 8;
  localparam int unsigned   SY_CS_N     = 22;
  localparam int unsigned   SY_SCLK     = 23;
  localparam int unsigned   SY_SI       = 24;
  localparam int unsigned   SY_INT_N    = 25;
  localparam int unsigned   SY_WAKE_N   = 26;
  localparam int unsigned   SY_VDD      = 27;
  localparam int unsigned   SY_THERMAL  = 28;
  localparam int unsigned   SY_TIMER    = 29;
  localparam logic [29:0]   SYNC_RST    = 30'h06400000;

endpackage

// [design/smsp_sync.sv]
/*
  Two-stage synchroniser for a bundle of asynchronous levels.
  Assumes the caller reads only the stable output; the first stage feeds the second alone.
*/
module smsp_sync #(
  parameter int unsigned        W       = 1,
  parameter logic [W-1:0]       RST_VAL = '0
) (
  input  wire logic             i_clk_sys,
  input  wire logic             i_reset_n,
  input  wire logic [W-1:0]     i_async,
  output logic      [W-1:0]     o_sync
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } smsp_sync_s;

  smsp_sync_s st_reg;
  smsp_sync_s st_next;

  // Next state: the first stage captures the pins, the second copies the first.
  always_comb begin
    st_next        = st_reg;
    st_next.meta   = i_async;
    st_next.stable = st_reg.meta;
  end

  // State register with synchronous reset to the idle levels.
  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      st_reg <= '{meta: RST_VAL, stable: RST_VAL};
    end else begin
      st_reg <= st_next;
    end
  end

  assign o_sync = st_reg.stable;

endmodule

// [design/smsp_top.sv]
/*
  Switch monitor serial port: serial slave, interrupt line and wake line control with
  Normal and Sleep modes, driven by comparator results for 22 switch inputs.
  Assumes the serial master, pins and comparators are asynchronous to the 40 MHz clock and
  that serial clock edges are at least several system clocks apart.
*/
module smsp_top (
  input  wire logic                          i_clk_sys,
  input  wire logic                          i_reset_n,
  input  wire logic                          i_cs_n,
  input  wire logic                          i_sclk,
  input  wire logic                          i_si,
  input  wire logic                          i_int_n,
  input  wire logic                          i_wake_n,
  input  wire logic                          i_vdd_present,
  input  wire logic                          i_thermal_flag,
  input  wire logic                          i_int_timer_expired,
  input  wire logic [smsp_pkg::NUM_PROG-1:0] i_programmable_switch_inputs,
  input  wire logic [smsp_pkg::NUM_GND-1:0]  i_ground_switch_inputs,
  output logic                               o_so,
  output logic                               o_so_oe,
  output logic                               o_int_out,
  output logic                               o_int_oe,
  output logic                               o_wake_out,
  output logic                               o_wake_oe,
  output logic                               o_normal_mode
);
  import smsp_pkg::*;

  // ************************************************************
  // State.
  // ************************************************************
  typedef struct packed {
    logic                   normal;
    logic                   cs_d;
    logic                   sclk_d;
    logic                   int_d;
    logic                   wake_d;
    logic                   timer_d;
    logic                   in_frame;
    logic [FRAME_BITS-1:0]  shift;
    logic [CNT_W-1:0]       bit_cnt;
    logic                   so;
    logic                   so_oe;
    logic                   int_pend;
    logic                   chg_in_frame;
    logic                   int_latched;
    logic                   reset_flag;
    logic [NUM_SW-1:0]      sw_prev;
    logic [2:0]             sw_valid;  // Fills with ones once the history is real.
    logic [NUM_PROG-1:0]    prog_bat;
    logic [NUM_PROG-1:0]    en_sp;
    logic [NUM_GND-1:0]     en_sg;
  } smsp_state_s;

  smsp_state_s       st_reg;
  smsp_state_s       st_next;
  logic [SYNC_W-1:0] sy;

  // Closed-contact vector: ground-type reads closed when the comparator sees below 4.0 V.
  function automatic logic [NUM_SW-1:0] closed_vec(input logic [NUM_PROG-1:0] bat,
                                                   input logic [NUM_PROG-1:0] cmp_p,
                                                   input logic [NUM_GND-1:0]  cmp_g);
    logic [NUM_SW-1:0] v;
    v = {~cmp_g, (bat & cmp_p) | (~bat & ~cmp_p)};
    return v;
  endfunction

  // Edge finders on a synchronised level and its registered copy.
  function automatic logic edge_fall(input logic prev, input logic now);
    return prev & ~now;
  endfunction

  function automatic logic edge_rise(input logic prev, input logic now);
    return ~prev & now;
  endfunction

  // ************************************************************
  // Synchronisation of every pin and comparator input.
  // ************************************************************
  smsp_sync #(
    .W       (SYNC_W),
    .RST_VAL (SYNC_RST)
  ) smsp_sync_i (
    .i_clk_sys (i_clk_sys),
    .i_reset_n (i_reset_n),
    .i_async   ({i_int_timer_expired, i_thermal_flag, i_vdd_present, i_wake_n, i_int_n,
                 i_si, i_sclk, i_cs_n, i_ground_switch_inputs,
                 i_programmable_switch_inputs}),
    .o_sync    (sy)
  );

  // ************************************************************
  // Edge detection and switch change detection.
  // ************************************************************
  logic              cs_s;
  logic              vdd_s;
  logic              cs_fall;
  logic              cs_rise;
  logic              sclk_rise;
  logic              sclk_fall;
  logic              int_fall;
  logic              wake_fall;
  logic              timer_rise;
  logic [NUM_SW-1:0] sw_now;
  logic              sw_change;
  logic              wake_any;
  logic              cmd_ok;
  logic [7:0]        cmd_code;

  // Edges compare the stable synchroniser output with its one-cycle copy.
  assign cs_s       = sy[SY_CS_N];
  assign vdd_s      = sy[SY_VDD];
  assign cs_fall    = edge_fall(st_reg.cs_d, cs_s);
  assign cs_rise    = edge_rise(st_reg.cs_d, cs_s);
  assign sclk_rise  = edge_rise(st_reg.sclk_d, sy[SY_SCLK]);
  assign sclk_fall  = edge_fall(st_reg.sclk_d, sy[SY_SCLK]);
  assign int_fall   = edge_fall(st_reg.int_d, sy[SY_INT_N]);
  assign wake_fall  = edge_fall(st_reg.wake_d, sy[SY_WAKE_N]);
  assign timer_rise = edge_rise(st_reg.timer_d, sy[SY_TIMER]);
  assign sw_now     = closed_vec(st_reg.prog_bat, sy[SY_GND_LO-1:SY_PROG_LO],
                                 sy[SY_CS_N-1:SY_GND_LO]);
  // Changes count only once the history holds synchronised levels, so that the
  // synchroniser's idle values after reset raise no false interrupt.
  assign sw_change  = st_reg.sw_valid[2] &
                      (|((sw_now ^ st_reg.sw_prev) & {st_reg.en_sg, st_reg.en_sp}));
  assign cmd_code   = st_reg.shift[FRAME_BITS-1:FRAME_BITS-8];

  // Wake sources while asleep; select and interrupt edges count only with logic supply.
  always_comb begin
    wake_any = sw_change | timer_rise;
    wake_any = wake_any | (wake_fall & (~vdd_s | sy[SY_INT_N]));
    wake_any = wake_any | (vdd_s & cs_fall);
    wake_any = wake_any | (vdd_s & int_fall & sy[SY_WAKE_N]);
  end

  // A command counts when at least one full word was clocked in Normal mode with supply.
  assign cmd_ok = cs_rise & st_reg.in_frame & st_reg.normal & vdd_s &
                  (st_reg.bit_cnt >= CNT_FRAME);

  // ************************************************************
  // Next-state logic.
  // ************************************************************
  always_comb begin
    st_next         = st_reg;
    st_next.cs_d    = cs_s;
    st_next.sclk_d  = sy[SY_SCLK];
    st_next.int_d   = sy[SY_INT_N];
    st_next.wake_d  = sy[SY_WAKE_N];
    st_next.timer_d = sy[SY_TIMER];
    st_next.sw_prev = sw_now;

    // The history-valid shift fills with ones in the cycles after reset.
    st_next.sw_valid = {st_reg.sw_valid[1:0], 1'b1};

    // Mode: Sleep ends on any wake source; supply loss alone never moves the mode.
    if (!st_reg.normal && wake_any) begin
      st_next.normal = 1'b1;
    end

    // Frame start: load status, open the driver and latch the interrupt line.
    if (cs_fall && vdd_s) begin
      st_next.in_frame     = 1'b1;
      st_next.so_oe        = 1'b1;
      st_next.int_latched  = sy[SY_INT_N];
      st_next.shift        = {sy[SY_THERMAL], st_reg.reset_flag, sw_now};
      st_next.so           = sy[SY_THERMAL];
      st_next.bit_cnt      = '0;
      st_next.chg_in_frame = 1'b0;
    end else if (st_reg.in_frame && !vdd_s) begin
      // Losing the logic supply aborts the frame without applying a command.
      st_next.in_frame = 1'b0;
      st_next.so_oe    = 1'b0;
    end else if (st_reg.in_frame && cs_rise) begin
      st_next.in_frame   = 1'b0;
      st_next.so_oe      = 1'b0;
      st_next.reset_flag = 1'b0;
    end else if (st_reg.in_frame && !cs_s) begin
      // Rising clock presents the top bit of the shift path, falling clock shifts data in.
      if (sclk_rise) begin
        st_next.so = st_reg.shift[FRAME_BITS-1];
      end
      if (sclk_fall) begin
        st_next.shift = {st_reg.shift[FRAME_BITS-2:0], sy[SY_SI]};
        if (st_reg.bit_cnt != CNT_MAX) begin
          st_next.bit_cnt = st_reg.bit_cnt + 6'h01;
        end
      end
    end

    // Apply the received word only at the end of the frame.
    if (cmd_ok) begin
      unique case (cmd_code)
        CMD_SETTINGS: st_next.prog_bat = st_reg.shift[NUM_PROG-1:0];
        CMD_WAKE_SP:  st_next.en_sp    = st_reg.shift[NUM_PROG-1:0];
        CMD_WAKE_SG:  st_next.en_sg    = st_reg.shift[NUM_GND-1:0];
        CMD_SLEEP:    st_next.normal   = 1'b0;
        default:      st_next.normal   = st_reg.normal;
      endcase
    end

    // Interrupt: a change sets it and wins over the release at chip select rise.
    if (cs_rise && st_reg.in_frame) begin
      st_next.int_pend = st_reg.chg_in_frame;
    end
    if (sw_change && (st_reg.normal || wake_any)) begin
      st_next.int_pend = 1'b1;
      if (st_reg.in_frame && !cs_rise) begin
        st_next.chg_in_frame = 1'b1;
      end
    end
  end

  // ************************************************************
  // State register.
  // ************************************************************
  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      st_reg              <= '0;
      st_reg.normal       <= 1'b1;
      st_reg.cs_d         <= 1'b1;
      st_reg.int_d        <= 1'b1;
      st_reg.wake_d       <= 1'b1;
      st_reg.int_latched  <= 1'b1;
      st_reg.reset_flag   <= 1'b1;
      st_reg.prog_bat     <= RST_PROG_BAT;
      st_reg.en_sp        <= RST_EN_SP;
      st_reg.en_sg        <= RST_EN_SG;
    end else begin
      st_reg <= st_next;
    end
  end

  // Output pins come straight from the state register; open-drain pins drive zero only.
  assign o_so          = st_reg.so;
  assign o_so_oe       = st_reg.so_oe;
  assign o_int_out     = st_reg.reset_flag & 1'b0;
  assign o_int_oe      = st_reg.int_pend;
  assign o_wake_out    = st_reg.reset_flag & 1'b0;
  assign o_wake_oe     = st_reg.normal;
  assign o_normal_mode = st_reg.normal;

  // ************************************************************
  // Checks.
  // ************************************************************
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_reset_n);

  chk_so_release: assert property (cs_rise && st_reg.in_frame |=> !o_so_oe)
    else $error("Output driver still on after chip select rise.");
  chk_frame_open: assert property (cs_fall && vdd_s |=> o_so_oe && st_reg.bit_cnt == 6'h00)
    else $error("Frame did not open on chip select fall.");
  chk_no_supply: assert property (cs_fall && !vdd_s |=> !o_so_oe)
    else $error("Frame opened without logic supply.");
  chk_msb_first: assert property (sclk_rise && st_reg.in_frame && !cs_s && vdd_s
                                  |=> o_so == $past(st_reg.shift[FRAME_BITS-1]))
    else $error("Serial output is not the top bit of the shift path.");
  chk_reset_clear: assert property (cs_rise && st_reg.in_frame && vdd_s |=> !st_reg.reset_flag)
    else $error("Reset flag survived chip select rise.");
  chk_int_release: assert property (cs_rise && st_reg.in_frame && !st_reg.chg_in_frame
                                    && !sw_change |=> !o_int_oe)
    else $error("Interrupt not released at chip select rise.");
  chk_int_assert: assert property (st_reg.normal && sw_change |=> o_int_oe [*2])
    else $error("Switch change did not hold the interrupt low.");
  chk_wake_line: assert property (!st_reg.normal && wake_fall && sy[SY_INT_N]
                                  |=> o_normal_mode && o_wake_oe)
    else $error("Wake line fall did not wake the device.");
  chk_sleep_hold: assert property (!st_reg.normal && !wake_any |=> !o_normal_mode)
    else $error("Device left Sleep without a wake source.");
  chk_cmd_apply: assert property (cmd_ok && cmd_code == CMD_SLEEP |=> !o_normal_mode)
    else $error("Sleep command not applied at chip select rise.");

  // ************************************************************
  // Checks on latching, shifting, interrupt cause and wake sources.
  // ************************************************************

  // The interrupt line level is captured when a frame opens.
  chk_int_latch: assert property (cs_fall && vdd_s
                                  |=> st_reg.int_latched == $past(sy[SY_INT_N]))
    else $error("Interrupt line level not latched at chip select fall.");
  // Each serial clock fall inside a frame shifts the data input in at the bottom.
  chk_shift_in: assert property (sclk_fall && st_reg.in_frame && !cs_s && vdd_s
                                 |=> st_reg.shift[0] == $past(sy[SY_SI]))
    else $error("Serial input not shifted in on clock fall.");
  // A short frame in Normal mode leaves the device in Normal mode.
  chk_short_frame: assert property (cs_rise && st_reg.in_frame && st_reg.normal &&
                                    st_reg.bit_cnt < CNT_FRAME |=> o_normal_mode)
    else $error("Command applied from a short frame.");
  // With chip select high the shift path holds still.
  chk_cs_ignore: assert property (cs_s && !st_reg.in_frame |=> $stable(st_reg.shift))
    else $error("Shift path moved while deselected.");
  // A change during the frame keeps the interrupt asserted past chip select rise.
  chk_int_kept: assert property (cs_rise && st_reg.in_frame && st_reg.chg_in_frame
                                 |=> o_int_oe)
    else $error("Interrupt released despite a change during the frame.");
  // Only an enabled switch change may assert the interrupt.
  chk_int_cause: assert property (!sw_change && !o_int_oe |=> !o_int_oe)
    else $error("Interrupt asserted without an enabled switch change.");
  // Losing the logic supply closes an open frame.
  chk_vdd_abort: assert property (st_reg.in_frame && !vdd_s
                                  |=> !o_so_oe && !st_reg.in_frame)
    else $error("Frame stayed open without logic supply.");
  // Without logic supply a chip select fall does not wake the device.
  chk_no_cs_wake: assert property (!st_reg.normal && !vdd_s && cs_fall && !sw_change &&
                                   !timer_rise && !wake_fall |=> !o_normal_mode)
    else $error("Chip select fall woke the device without logic supply.");
  // The interrupt timer wakes a sleeping device.
  chk_timer_wake: assert property (!st_reg.normal && timer_rise |=> o_normal_mode)
    else $error("Interrupt timer did not wake the device.");

  cov_full_frame: cover property (cs_rise && st_reg.in_frame && st_reg.bit_cnt == CNT_FRAME);
  cov_timer_wake: cover property (!st_reg.normal && timer_rise ##1 o_normal_mode);
  cov_chain_frame: cover property (cs_rise && st_reg.in_frame && st_reg.bit_cnt == 6'h30);
  cov_int_wake: cover property (!st_reg.normal && int_fall && vdd_s ##1 o_normal_mode);
  cov_int_kept: cover property (cs_rise && st_reg.chg_in_frame ##1 o_int_oe);

endmodule

// [sim/smsp_host.sv]
/*
  Host model: the serial master that selects the switch monitor port and runs frames.
  Assumes the bench system clock; pins change only at its falling edges, 200 ns per bit.
*/
module smsp_host (
  input  wire logic i_clk_sys,
  input  wire logic i_so,
  input  wire logic i_so_oe,
  output logic      o_cs_n,
  output logic      o_sclk,
  output logic      o_si
);
  timeunit 1ns;
  timeprecision 1ps;

  // Deselected with the serial clock parked low while idle.
  initial begin
    o_cs_n = 1'b1;
    o_sclk = 1'b0;
    o_si   = 1'b0;
  end

  // ************************************************************
  // Frame of nbits clocks, the low nbits of tx sent MSB first.
  // ************************************************************
  // A floating output line reads as unknown, so an undriven bit never matches.
  task automatic frame(input logic [47:0] tx, input int nbits, output logic [47:0] rx);
    rx = '0;
    o_cs_n = 1'b0;
    repeat (8) @(negedge i_clk_sys);
    for (int b = nbits - 1; b >= 0; b--) begin
      o_sclk = 1'b1;
      o_si   = tx[b];
      repeat (4) @(negedge i_clk_sys);
      o_sclk = 1'b0;
      rx = {rx[46:0], (i_so_oe === 1'b1) ? i_so : 1'bx};
      repeat (4) @(negedge i_clk_sys);
    end
    o_cs_n = 1'b1;
    o_si   = ~o_si;
    repeat (8) @(negedge i_clk_sys);
  endtask
endmodule

// [sim/switch_monitor_serial_port_test.sv]
/*
  Self-checking bench for the switch monitor serial port with a host model on its link.
  Assumes the shared interrupt and wake wires have pull-ups that the bench resolves.
*/
module switch_monitor_serial_port_test;
  timeunit 1ns;
  timeprecision 1ps;
  import smsp_pkg::*;

  logic        clk, rst_n, cs_n, sclk, si, ext_int_n, ext_wake_n, vdd, thermal, timer;
  logic [7:0]  prog;
  logic [13:0] gnd;
  logic        so, so_oe, int_out, int_oe, wake_out, wake_oe, normal;
  logic [47:0] rx;
  int          n_errors = 0;
  int          checked  = 0;
  int          cycles   = 0;

  // Open-drain wires: pulled up unless some party pulls them low.
  wire int_n  = ext_int_n & ~int_oe;
  wire wake_n = ext_wake_n & ~wake_oe;

  smsp_host host_i (.i_clk_sys(clk), .i_so(so), .i_so_oe(so_oe), .o_cs_n(cs_n),
                    .o_sclk(sclk), .o_si(si));

  smsp_top smsp_top_i (.i_clk_sys(clk), .i_reset_n(rst_n), .i_cs_n(cs_n), .i_sclk(sclk),
    .i_si(si), .i_int_n(int_n), .i_wake_n(wake_n), .i_vdd_present(vdd),
    .i_thermal_flag(thermal), .i_int_timer_expired(timer),
    .i_programmable_switch_inputs(prog), .i_ground_switch_inputs(gnd), .o_so(so),
    .o_so_oe(so_oe), .o_int_out(int_out), .o_int_oe(int_oe), .o_wake_out(wake_out),
    .o_wake_oe(wake_oe), .o_normal_mode(normal));

  // ************************************************************
  // Clock, timeout, compare and verdict.
  // ************************************************************
  // The system clock toggles every half period of 12.5 ns.
  always #12.5 clk = ~clk;

  // Cuts a hang short well above the expected run of about 3800 cycles.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      report_and_stop();
    end
  end

  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic report_and_stop();
    if (n_errors == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic wt(input int n);
    repeat (n) @(negedge clk);
  endtask

  // Expected response: closed reads one, battery type closes above the threshold.
  function automatic logic [47:0] st(input logic rf, input logic [7:0] bat);
    return 48'({thermal, rf, ~gnd, ~(prog ^ bat)});
  endfunction

  // ************************************************************
  // Scenarios.
  // ************************************************************
  task automatic t_reset();
    chk(48'({so_oe, int_oe, wake_oe, normal}), 48'h3);
    chk(48'({int_out, wake_out}), 48'h0);
    host_i.frame(48'h0, 24, rx);
    chk(rx, st(1'b1, 8'hff));
    chk(48'(so_oe), 48'h0);
    host_i.frame(48'h0, 24, rx);
    chk(rx, st(1'b0, 8'hff));
  endtask

  task automatic t_settings();
    host_i.frame(48'({CMD_SETTINGS, 16'h000f}), 24, rx);
    chk(rx, st(1'b0, 8'hff));
    host_i.frame(48'h0, 24, rx);
    chk(rx, st(1'b0, 8'h0f));
  endtask

  task automatic t_int();
    host_i.frame(48'h0, 24, rx);
    chk(48'(int_oe), 48'h0);
    gnd[0] = ~gnd[0];
    wt(8);
    chk(48'(int_oe), 48'h1);
    host_i.frame(48'h0, 24, rx);
    chk(48'(int_oe), 48'h0);
    fork
      host_i.frame(48'h0, 24, rx);
      begin
        wt(60);
        gnd[0] = ~gnd[0];
      end
    join
    chk(48'(int_oe), 48'h1);
    host_i.frame(48'({CMD_WAKE_SG, 16'h3ffe}), 24, rx);
    gnd[0] = ~gnd[0];
    wt(8);
    chk(48'(int_oe), 48'h0);
    host_i.frame(48'({CMD_WAKE_SG, 16'h3fff}), 24, rx);
  endtask

  task automatic t_chain();
    logic [47:0] exp;
    exp = st(1'b0, 8'h0f);
    host_i.frame({24'h5a3c96, 24'h0}, 48, rx);
    chk(rx, {exp[23:0], 24'h5a3c96});
  endtask

  task automatic t_sleep();
    host_i.frame(48'({CMD_SLEEP, 16'h0}), 23, rx);
    chk(48'(normal), 48'h1);
    host_i.frame(48'({CMD_SLEEP, 16'h0}), 24, rx);
    chk(48'({normal, wake_oe}), 48'h0);
    host_i.frame(48'h0, 24, rx);
    chk(48'(normal), 48'h1);
    host_i.frame(48'({CMD_SLEEP, 16'h0}), 24, rx);
    vdd = 1'b0;
    wt(8);
    host_i.frame(48'h0, 24, rx);
    chk(48'({normal, so_oe}), 48'h0);
    ext_wake_n = 1'b0;
    wt(8);
    chk(48'(normal), 48'h1);
    ext_wake_n = 1'b1;
    vdd = 1'b1;
    wt(8);
    host_i.frame(48'({CMD_SLEEP, 16'h0}), 24, rx);
    ext_int_n = 1'b0;
    wt(8);
    chk(48'(normal), 48'h1);
    ext_int_n = 1'b1;
    vdd = 1'b0;
    wt(8);
    chk(48'(normal), 48'h1);
    vdd = 1'b1;
    wt(8);
    host_i.frame(48'({CMD_SLEEP, 16'h0}), 24, rx);
    chk(48'(normal), 48'h0);
    timer = 1'b1;
    wt(8);
    chk(48'(normal), 48'h1);
    timer = 1'b0;
  endtask

  // Main sequence: reset held six cycles, then every scenario in turn.
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    ext_int_n = 1'b1;
    ext_wake_n = 1'b1;
    vdd = 1'b1;
    thermal = 1'b1;
    timer = 1'b0;
    prog = 8'ha5;
    gnd = 14'h0f0f;
    wt(6);
    rst_n = 1'b1;
    wt(2);
    t_reset();
    t_settings();
    t_int();
    t_chain();
    t_sleep();
    report_and_stop();
  end
endmodule
